// ==== design/pswc_consts.svh ====
// Constants for the PID sleep and wake controller
`ifndef PSWC_CONSTS_SVH
`define PSWC_CONSTS_SVH
// ===========================================================
// Timing
`define PSWC_CLK_HZ          40000000
`define PSWC_TICK_S_DIV      10
`define PSWC_TICK_CYCLES     (`PSWC_CLK_HZ / `PSWC_TICK_S_DIV)
`define PSWC_TICK_DEF        32'h003D_0900
// ===========================================================
// Field widths and limits (scaled units)
`define PSWC_DELAY_MAX       16'h2707
`define PSWC_FILT_MAX_MS     16'h2707
`define PSWC_SPEED_MAX       16'h0FA0
`define PSWC_DEV_MAX         16'h2707
// ===========================================================
// Mode codes
`define PSWC_PID_MANUAL      2'h0
`define PSWC_PID_AUTO        2'h1
`define PSWC_PID_BY_INPUT    2'h2
`endif

// ==== design/pswc_controller.sv ====
// Sleep/wake supervisor with setpoint smoothing filter
// Functional notes
// - Setpoint passes a first-order low-pass filter, time constant 0 to 9.991 s.
// - Sleep only allowed with PID enabled and in automatic mode.
// - Process variable keeps being evaluated while asleep.
// - Wake threshold is setpoint minus deviation (direct) or plus (reverse).
// - Wake when process below threshold (direct) or above it (reverse).
// - Motor starts only after wake condition held for wake_delay.
// - Wake timer clears when the condition drops early.
// - At power-up with run and wake both active, start at once.
// - Speed below sleep_speed_threshold is the sleep condition.
// - Threshold of zero disables sleep; run/stop alone drives motor.
// - Sleep entered after speed stays below threshold for sleep_delay.
// - Sleep alarm raised while asleep.
// - Run without wake condition keeps motor stopped in sleep.
// - On waking ramp to minimum speed first, then enable PID.
// - On sleep decelerate to 0 Hz, hold, put PID in sleep.
// - Action polarity selects wake comparison direction.
// - Mode 2 selects manual or automatic from mode_select_input.
`include "pswc_consts.svh"
module pswc_controller #(
   parameter logic [21:0] TICK_CYCLES = 22'(`PSWC_TICK_CYCLES)
) (
   input  wire logic                clk_sys,
   input  wire logic                nrst,
   input  wire pswc_pkg::pswc_cfg_t cfg,
   input  wire pswc_pkg::pswc_proc_t proc_in,
   output      pswc_pkg::pswc_cmd_t cmd
);
   import pswc_pkg::*;

   pswc_regs_t         r_reg;
   pswc_regs_t         r_next;
   logic               auto_mode;
   logic               sleep_allowed;
   logic signed [16:0] wake_thr;
   logic               wake_now;
   logic               slow_now;
   logic signed [31:0] err;
   logic [15:0]        ms_div;

   // ===========================================================
   // Condition evaluation, runs in every state, asleep included
   always_comb
   begin
      unique case (cfg.pid_mode_select)
         `PSWC_PID_AUTO:     auto_mode = 1'b1;
         `PSWC_PID_BY_INPUT: auto_mode = proc_in.mode_select_input;
         default:            auto_mode = 1'b0;
      endcase
      sleep_allowed = cfg.pid_enable && auto_mode
                      && (cfg.sleep_speed_threshold != 16'h0000);
      if (cfg.reverse_action)
         wake_thr = 17'(r_reg.cmd.filtered_setpoint) + 17'(cfg.wake_deviation);
      else
         wake_thr = 17'(r_reg.cmd.filtered_setpoint) - 17'(cfg.wake_deviation);
      wake_now = cfg.reverse_action ? (17'(proc_in.process_value) > wake_thr)
                                    : (17'(proc_in.process_value) < wake_thr);
      slow_now = proc_in.motor_speed < cfg.sleep_speed_threshold;
   end

   // ===========================================================
   // Next-state logic
   always_comb
   begin
      r_next = r_reg;
      ms_div = (cfg.filter_time_ms == 16'h0000) ? 16'h0001 : cfg.filter_time_ms;
      err    = 32'sh0000_0000;
      // Tick divider
      r_next.tick = 1'b0;
      if (r_reg.tick_cnt >= TICK_CYCLES - 22'h00_0001)
      begin
         r_next.tick_cnt = 22'h00_0000;
         r_next.tick     = 1'b1;
      end
      else
         r_next.tick_cnt = r_reg.tick_cnt + 22'h00_0001;
      // Filter step once per millisecond; acc holds setpoint scaled by 2^8
      r_next.filt_acc = r_reg.filt_acc;
      if (r_reg.ms_pre == 6'h27)
      begin
         r_next.ms_pre = 6'h00;
         if (r_reg.ms_cnt >= 16'h03E7)
         begin
            r_next.ms_cnt = 16'h0000;
            // Integer divide per ms: costly, and combinational, so it must settle within one clock cycle
            err = ({{16{proc_in.setpoint[15]}}, proc_in.setpoint} <<< 8) - r_reg.filt_acc;
            if (cfg.filter_time_ms == 16'h0000)
               r_next.filt_acc = {{16{proc_in.setpoint[15]}}, proc_in.setpoint} <<< 8;
            else
               r_next.filt_acc = r_reg.filt_acc + err / $signed({16'h0000, ms_div});
         end
         else
            r_next.ms_cnt = r_reg.ms_cnt + 16'h0001;
      end
      else
      begin
         r_next.ms_pre = r_reg.ms_pre + 6'h01;
         err = 32'sh0000_0000;
      end
      // Zero time constant: follow the setpoint every cycle, not once a millisecond
      if (cfg.filter_time_ms == 16'h0000)
         r_next.filt_acc = {{16{proc_in.setpoint[15]}}, proc_in.setpoint} <<< 8;
      r_next.cmd.filtered_setpoint = r_next.filt_acc[23:8];
      // Wake timer
      if (!wake_now)
         r_next.wake_cnt = 16'h0000;
      else if (r_reg.tick && r_reg.wake_cnt != 16'hFFFF)
         r_next.wake_cnt = r_reg.wake_cnt + 16'h0001;
      // Sleep timer
      if (!slow_now || r_reg.state != PSWC_ST_RUN)
         r_next.sleep_cnt = 16'h0000;
      else if (r_reg.tick && r_reg.sleep_cnt != 16'hFFFF)
         r_next.sleep_cnt = r_reg.sleep_cnt + 16'h0001;
      r_next.powerup = 1'b0;
      unique case (r_reg.state)
         PSWC_ST_IDLE:
            if (proc_in.run_stop_input)
            begin
               if (!sleep_allowed)
                  r_next.state = PSWC_ST_RUN;
               else if (r_reg.powerup && wake_now)
                  r_next.state = PSWC_ST_ACCEL;
               else
                  r_next.state = PSWC_ST_SLEEP;
            end
         PSWC_ST_SLEEP:
            if (!proc_in.run_stop_input || !sleep_allowed)
               r_next.state = PSWC_ST_IDLE;
            else if (wake_now && r_reg.wake_cnt >= cfg.wake_delay)
               r_next.state = PSWC_ST_ACCEL;
         PSWC_ST_ACCEL:
            if (!proc_in.run_stop_input)
               r_next.state = PSWC_ST_IDLE;
            else if (proc_in.motor_speed >= cfg.minimum_speed)
               r_next.state = PSWC_ST_RUN;
         PSWC_ST_RUN:
            if (!proc_in.run_stop_input)
               r_next.state = PSWC_ST_IDLE;
            else if (sleep_allowed && slow_now && r_reg.sleep_cnt >= cfg.sleep_delay)
               r_next.state = PSWC_ST_DECEL;
         PSWC_ST_DECEL:
            if (!proc_in.run_stop_input)
               r_next.state = PSWC_ST_IDLE;
            else if (proc_in.motor_speed == 16'h0000)
               r_next.state = PSWC_ST_SLEEP;
         default:
            r_next.state = PSWC_ST_IDLE;
      endcase
      // Outputs decoded from the coming state, wake_cond from wake_now
      r_next.cmd.motor_on      = (r_next.state == PSWC_ST_ACCEL) || (r_next.state == PSWC_ST_RUN);
      r_next.cmd.ramp_to_min   = (r_next.state == PSWC_ST_ACCEL);
      r_next.cmd.pid_active    = (r_next.state == PSWC_ST_RUN);
      r_next.cmd.decel_to_zero = (r_next.state == PSWC_ST_DECEL)
                                 || (r_next.state == PSWC_ST_SLEEP);
      r_next.cmd.pid_sleep     = (r_next.state == PSWC_ST_SLEEP);
      r_next.cmd.sleep_alarm   = (r_next.state == PSWC_ST_SLEEP);
      r_next.cmd.wake_cond     = wake_now;
   end

   // ===========================================================
   // State register
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         r_reg         <= '0;
         r_reg.state   <= PSWC_ST_IDLE;
         r_reg.powerup <= 1'b1;
      end
      else
         r_reg <= r_next;
   end

   assign cmd = r_reg.cmd;
endmodule : pswc_controller

// ==== design/pswc_pkg.sv ====
// Types for the PID sleep and wake controller
package pswc_pkg;
   // ===========================================================
   // Controller states
   typedef enum logic [2:0] {
      PSWC_ST_IDLE  = 3'b000,
      PSWC_ST_SLEEP = 3'b001,
      PSWC_ST_ACCEL = 3'b010,
      PSWC_ST_RUN   = 3'b011,
      PSWC_ST_DECEL = 3'b100
   } pswc_state_t;

   // Settings, fixed-point: delays in 0.1 s, filter time in ms, speed in 0.1 Hz, deviation in 0.01
   typedef struct packed {
      logic [15:0]        filter_time_ms;
      logic signed [15:0] wake_deviation;
      logic [15:0]        wake_delay;
      logic [15:0]        sleep_speed_threshold;
      logic [15:0]        sleep_delay;
      logic [15:0]        minimum_speed;
      logic [1:0]         pid_mode_select;
      logic               reverse_action;
      logic               pid_enable;
   } pswc_cfg_t;

   // Live process signals
   typedef struct packed {
      logic signed [15:0] setpoint;
      logic signed [15:0] process_value;
      logic [15:0]        motor_speed;
      logic               run_stop_input;
      logic               mode_select_input;
   } pswc_proc_t;

   // Commands to the drive stage
   typedef struct packed {
      logic               motor_on;
      logic               ramp_to_min;
      logic               decel_to_zero;
      logic               pid_active;
      logic               pid_sleep;
      logic               sleep_alarm;
      logic               wake_cond;
      logic signed [15:0] filtered_setpoint;
   } pswc_cmd_t;

   typedef struct packed {
      pswc_state_t        state;
      logic [21:0]        tick_cnt;
      logic               tick;
      logic [15:0]        ms_cnt;
      logic [5:0]         ms_pre;
      logic [15:0]        wake_cnt;
      logic [15:0]        sleep_cnt;
      logic               powerup;
      logic signed [31:0] filt_acc;
      pswc_cmd_t          cmd;
   } pswc_regs_t;
endpackage : pswc_pkg

// ==== sim/pswc_controller_tb.sv ====
// Self-checking bench for the sleep and wake controller
module pswc_controller_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pswc_pkg::*;
   // ==========================================================
   // Signals
   localparam int BRAMP = 21;
   localparam int BRUN  = 19;
   localparam int BSLP  = 17;
   logic        clk_sys = 1'b0;
   logic        nrst = 1'b0;
   pswc_cfg_t   cfg;
   pswc_proc_t  pin;
   pswc_proc_t  pdut;
   pswc_cmd_t   cmd;
   logic [15:0] demand;
   logic [15:0] speed;
   int          fail_count = 0;
   int          checked = 0;
   int          c;
   always #12.5 clk_sys = ~clk_sys;
   assign pdut = pswc_proc_t'({pin[49:18], speed, pin[1:0]});
   pswc_controller #(.TICK_CYCLES(22'h00_000A)) uut (.clk_sys(clk_sys), .nrst(nrst), .cfg(cfg),
      .proc_in(pdut), .cmd(cmd));
   pswc_motor drive (.clk_sys(clk_sys), .nrst(nrst), .cmd(cmd), .demand(demand), .speed(speed));
   // ==========================================================
   // Helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc
   task automatic wt(input int b, output int n);
      for (n = 0; n < 2000 && cmd[b] !== 1'b1; n++) @(negedge clk_sys);
      if (n == 2000)
      begin
         fail_count++;
         complete_run();
      end
   endtask : wt
   task automatic complete_run();
      $display("checks %0d bad %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   // ==========================================================
   // Scenarios
   task automatic t_powerup();
      cyc(2);
      chk(16'(cmd.ramp_to_min), 16'h0001);
      wt(BRUN, c);
      chk(16'(cmd.ramp_to_min), 16'h0000);
      chk(cmd.filtered_setpoint, 16'h03E8);
      $display("done powerup");
   endtask : t_powerup
   task automatic t_sleep();
      pin.process_value = 16'sh03E8;
      demand = 16'h0032;
      wt(BSLP, c);
      chk(16'(c >= 55), 16'h0001);
      chk(16'(cmd.pid_sleep), 16'h0001);
      $display("done sleep");
   endtask : t_sleep
   task automatic t_wake();
      demand = 16'h0258;
      cyc(60);
      chk(16'(cmd.sleep_alarm), 16'h0001);
      cfg.reverse_action = 1'b1;
      pin.process_value = 16'sh04B0;
      cyc(3);
      chk(16'(cmd.wake_cond), 16'h0001);
      cfg.reverse_action = 1'b0;
      cyc(3);
      chk(16'(cmd.wake_cond), 16'h0000);
      pin.process_value = 16'shFF38;
      cyc(15);
      chk(16'(cmd.wake_cond), 16'h0001);
      pin.process_value = 16'sh03E8;
      cyc(2);
      pin.process_value = 16'shFF38;
      wt(BRAMP, c);
      chk(16'(c > 15), 16'h0001);
      $display("done wake");
   endtask : t_wake
   task automatic t_nosleep();
      wt(BRUN, c);
      cfg.sleep_speed_threshold = 16'h0000;
      demand = 16'h0032;
      cyc(80);
      chk(16'(cmd.motor_on), 16'h0001);
      pin.run_stop_input = 1'b0;
      cyc(2);
      chk(16'(cmd.motor_on), 16'h0000);
      cfg.sleep_speed_threshold = 16'h0064;
      cfg.pid_enable = 1'b0;
      pin.run_stop_input = 1'b1;
      cyc(80);
      chk(16'(cmd.sleep_alarm), 16'h0000);
      cfg.pid_enable = 1'b1;
      cfg.pid_mode_select = 2'h2;
      pin.mode_select_input = 1'b0;
      cyc(80);
      chk(16'(cmd.sleep_alarm), 16'h0000);
      pin.mode_select_input = 1'b1;
      wt(BSLP, c);
      chk(16'(cmd.pid_sleep), 16'h0001);
      $display("done nosleep");
   endtask : t_nosleep
   initial
   begin
      cfg = '{16'h0000, 16'sh0064, 16'h0003, 16'h0064, 16'h0002, 16'h01F4, 2'h1, 1'b0, 1'b1};
      pin = '{16'sh03E8, 16'shFF38, 16'h0000, 1'b1, 1'b1};
      demand = 16'h0258;
      cyc(4);
      nrst = 1'b1;
      t_powerup();
      t_sleep();
      t_wake();
      t_nosleep();
      complete_run();
   end
endmodule : pswc_controller_tb

// ==== sim/pswc_motor.sv ====
// Drive stage model: speed follows the controller commands
module pswc_motor (
   input  wire logic                clk_sys,
   input  wire logic                nrst,
   input  wire pswc_pkg::pswc_cmd_t cmd,
   input  wire logic [15:0]         demand,
   output      logic [15:0]         speed
);
   import pswc_pkg::*;
   // Slew of 1 Hz a cycle keeps ramps short; demand must be a multiple of it
   always_ff @(posedge clk_sys or negedge nrst)
      if (!nrst) speed <= 16'h0000;
      else if (!cmd.motor_on || cmd.decel_to_zero) speed <= (speed > 16'h000A) ? speed - 16'h000A : 16'h0000;
      else if (speed < demand) speed <= speed + 16'h000A;
      else if (speed > demand) speed <= speed - 16'h000A;
endmodule : pswc_motor

// ==== sim/pswc_props.sv ====
// Checker for the sleep and wake controller
module pswc_props #(
   parameter logic [21:0] TICK_CYCLES = 22'h00_000A
) (
   input wire logic                 clk_sys,
   input wire logic                 nrst,
   input wire pswc_pkg::pswc_cfg_t  cfg,
   input wire pswc_pkg::pswc_proc_t proc_in,
   input wire pswc_pkg::pswc_cmd_t  cmd
);
   import pswc_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // ==========================================================
   // Assertions
   a_sleep_outputs: assert property (cmd.sleep_alarm |-> cmd.pid_sleep && !cmd.motor_on)
      else $error("sleep outputs wrong");
   a_zero_thresh: assert property (cfg.sleep_speed_threshold == 16'h0000 && !cmd.sleep_alarm
      |=> !cmd.sleep_alarm) else $error("sleep with zero threshold");
   a_pid_off: assert property (!cfg.pid_enable && !cmd.sleep_alarm |=> !cmd.sleep_alarm)
      else $error("sleep with pid disabled");
   a_manual_mode: assert property (cfg.pid_mode_select == 2'h2 && !proc_in.mode_select_input
      && !cmd.sleep_alarm |=> !cmd.sleep_alarm) else $error("sleep in manual mode");
   a_run_low: assert property (!proc_in.run_stop_input |=> !cmd.motor_on)
      else $error("motor on without run");
   a_accel_first: assert property (cmd.ramp_to_min |-> !cmd.pid_active)
      else $error("pid active during ramp");
   a_accel_done: assert property (cmd.ramp_to_min && proc_in.run_stop_input
      && proc_in.motor_speed >= cfg.minimum_speed |=> cmd.pid_active) else $error("no pid");
   a_decel_done: assert property (cmd.decel_to_zero && !cmd.sleep_alarm
      && proc_in.run_stop_input && proc_in.motor_speed == 16'h0000 |=> cmd.sleep_alarm)
      else $error("no sleep at zero speed");
   // Nonzero delay only: a zero delay may legally wake on the next edge
   a_no_wake: assert property (cmd.sleep_alarm && !cmd.wake_cond
      && cfg.wake_delay != 16'h0000 |=> !cmd.ramp_to_min) else $error("woke without cause");
   c_sleep: cover property (cmd.sleep_alarm);
   c_wake: cover property ($rose(cmd.ramp_to_min));
   c_run: cover property (cmd.pid_active);
endmodule : pswc_props
bind pswc_controller pswc_props #(.TICK_CYCLES(TICK_CYCLES)) props_i (.clk_sys(clk_sys),
   .nrst(nrst), .cfg(cfg), .proc_in(proc_in), .cmd(cmd));
